// File: vcr_params.svh
// Purpose: named constants of the cursor, origin and retrace group
// Assumes: 8-bit index/data register port, 16-bit I/O address
// Notes: included by the cursor unit, the top block and the bench, not by the package or the interface
`ifndef VCR_PARAMS_SVH
`define VCR_PARAMS_SVH

// ----------------------------------------------------------------
// host port addresses
// ----------------------------------------------------------------
`define VCR_IDX_PORT_MONO 16'h03b4
`define VCR_DAT_PORT_MONO 16'h03b5
`define VCR_IDX_PORT_COLOR 16'h03d4
`define VCR_DAT_PORT_COLOR 16'h03d5

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define VCR_IDX_CUR_TOP 8'h0a
`define VCR_IDX_CUR_BOT 8'h0b
`define VCR_IDX_ORG_UP 8'h0c
`define VCR_IDX_ORG_LO 8'h0d
`define VCR_IDX_CPOS_UP 8'h0e
`define VCR_IDX_CPOS_LO 8'h0f
`define VCR_IDX_RT_BEGIN 8'h10
`define VCR_IDX_RT_END 8'h11

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define VCR_REG_RESET 8'h00
`define VCR_IDX_RESET 8'h00
`define VCR_LINE_MSB 4
`define VCR_CUR_ON_BIT 5
`define VCR_STRIKE_MSB 7
`define VCR_STRIKE_LSB 6
`define VCR_DELAY_MSB 6
`define VCR_DELAY_LSB 5
`define VCR_LOCK_BIT 7
`define VCR_FIVE_CYC_BIT 6
`define VCR_IRQ_EN_N_BIT 5
`define VCR_IRQ_CLR_N_BIT 4
`define VCR_RT_END_MSB 3

// ----------------------------------------------------------------
// strike-through line per select code
// ----------------------------------------------------------------
`define VCR_STRIKE_L0 5'h01
`define VCR_STRIKE_L1 5'h05
`define VCR_STRIKE_L2 5'h09
`define VCR_STRIKE_L3 5'h0d

`endif

// File: vcr_pkg.sv
// Purpose: types shared by the cursor, origin and retrace group
// Assumes: nothing beyond the params header
// Notes: states of the retrace sequencer
package vcr_pkg;

  typedef enum logic [0:0] {
    VCR_RT_IDLE = 1'b0,
    VCR_RT_ACTIVE = 1'b1
  } vcr_rt_state_t;

  typedef logic [15:0] vcr_addr_t;

endpackage

// File: vcr_cur_if.sv
// Purpose: cursor shape and position from register file to cursor unit
// Assumes: single clock domain
// Notes: src side is the register file
`timescale 1ns/100ps
interface vcr_cur_if;
  import vcr_pkg::*;
  logic [4:0] top_line;
  logic [4:0] bot_line;
  logic on;
  logic [1:0] delay;
  vcr_addr_t pos;
  modport src(output top_line, bot_line, on, delay, pos);
  modport snk(input top_line, bot_line, on, delay, pos);
endinterface

// File: vcr_cursor.sv
// Purpose: text cursor hit test and character-time delay
// Assumes: i_char_tick pulses once per character time
// Notes: output registered every clock
`timescale 1ns/100ps
`include "vcr_params.svh"
module vcr_cursor
  import vcr_pkg::*;
#(
  parameter int MAX_DELAY = 3
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  vcr_cur_if.snk cfg,
  input wire logic i_char_tick,
  input wire logic [4:0] i_row_scan,
  input wire vcr_addr_t i_char_addr,
  output logic o_cursor_pix
);

  function automatic logic in_span(input logic [4:0] v,
                                   input logic [4:0] lo,
                                   input logic [4:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction

  logic hit_w;
  logic [MAX_DELAY-1:0] stage_r;
  logic [MAX_DELAY-1:0] stage_nxt;
  logic pix_nxt;

  // ----------------------------------------------------------------
  // hit test and delay line
  // ----------------------------------------------------------------
  always_comb begin
    hit_w = cfg.on && (cfg.top_line <= cfg.bot_line) &&
            (i_char_addr == cfg.pos) &&
            in_span(i_row_scan, cfg.top_line, cfg.bot_line);
    stage_nxt = stage_r;
    if (i_char_tick) begin
      stage_nxt = {stage_r[MAX_DELAY-2:0], hit_w};
    end
    if (cfg.delay == 2'h0) begin
      pix_nxt = hit_w;
    end else begin
      pix_nxt = stage_r[cfg.delay - 2'h1];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage_r <= '0;
      o_cursor_pix <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      o_cursor_pix <= pix_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cursor_inverted: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cfg.top_line > cfg.bot_line) && (cfg.delay == 2'h0) |=> !o_cursor_pix)
    else $error("cursor shown with inverted shape");

  a_cursor_off: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !cfg.on && (cfg.delay == 2'h0) |=> !o_cursor_pix)
    else $error("cursor shown while switched off");

  a_cursor_skew_one: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_char_tick && hit_w && (cfg.delay == 2'h1) ##1 (cfg.delay == 2'h1)
    |=> o_cursor_pix)
    else $error("cursor not delayed by one character");

endmodule

// File: vcr_top.sv
// Purpose: cursor shape, display origin and vertical retrace registers
// Assumes: all inputs come from logic on i_core_clk
// Notes: host reaches registers through an index and a data port
//
// What this block does
// - cursor top register at data port, index 0a
// - no cursor when top line exceeds bottom
// - low five bits give cursor first line
// - strike select picks line 1, 5, 9, 13
// - strike select honoured only with extended attributes
// - cursor delayed zero to three character times
// - low five bits give cursor last line
// - origin is upper byte then lower byte
// - origin loaded as first address after retrace
// - cursor position from upper and lower bytes
// - retrace begins when scan line equals start
// - start bits eight and nine from overflow
// - retrace registers reached only with readback enabled
// - lock bit only drives o_register_write_lock, no write is blocked
// - enable bit low latches retrace flag
// - retrace ends on low four bits match
`timescale 1ns/100ps
`include "vcr_params.svh"
module vcr_top
  import vcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_color_mode,
  input wire logic i_extended_attr_enable,
  input wire logic i_timing_reg_readback,
  input wire logic [1:0] i_ovf_retrace_hi,
  input wire logic i_line_tick,
  input wire logic [9:0] i_scan_line,
  input wire logic i_char_tick,
  input wire logic [4:0] i_row_scan,
  input wire vcr_addr_t i_char_addr,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_valid,
  output logic o_cursor_pix,
  output logic o_strike_hit,
  output logic o_vretrace,
  output logic o_retrace_flag,
  output vcr_addr_t o_origin_addr,
  output logic o_origin_load,
  output logic o_register_write_lock,
  output logic o_refresh_five_cycles
);

  vcr_cur_if cur_if ();

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] idx_r, idx_nxt;
  logic [7:0] cur_top_r, cur_top_nxt;
  logic [7:0] cur_bot_r, cur_bot_nxt;
  logic [7:0] org_up_r, org_up_nxt;
  logic [7:0] org_lo_r, org_lo_nxt;
  logic [7:0] cpos_up_r, cpos_up_nxt;
  logic [7:0] cpos_lo_r, cpos_lo_nxt;
  logic [7:0] rt_begin_r, rt_begin_nxt;
  logic [7:0] rt_end_r, rt_end_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic idx_sel;
  logic dat_sel;

  // ports follow mono or colour mode
  assign idx_sel = i_color_mode ? (i_io_addr == `VCR_IDX_PORT_COLOR)
                                : (i_io_addr == `VCR_IDX_PORT_MONO);
  assign dat_sel = i_color_mode ? (i_io_addr == `VCR_DAT_PORT_COLOR)
                                : (i_io_addr == `VCR_DAT_PORT_MONO);

  always_comb begin
    idx_nxt = idx_r;
    cur_top_nxt = cur_top_r;
    cur_bot_nxt = cur_bot_r;
    org_up_nxt = org_up_r;
    org_lo_nxt = org_lo_r;
    cpos_up_nxt = cpos_up_r;
    cpos_lo_nxt = cpos_lo_r;
    rt_begin_nxt = rt_begin_r;
    rt_end_nxt = rt_end_r;
    rdata_nxt = 8'h00;
    rvalid_nxt = 1'b0;
    if (i_io_wr && idx_sel) begin
      idx_nxt = i_io_wdata;
    end
    if (i_io_wr && dat_sel) begin
      case (idx_r)
        `VCR_IDX_CUR_TOP: cur_top_nxt = i_io_wdata;
        `VCR_IDX_CUR_BOT: cur_bot_nxt = i_io_wdata;
        `VCR_IDX_ORG_UP: org_up_nxt = i_io_wdata;
        `VCR_IDX_ORG_LO: org_lo_nxt = i_io_wdata;
        `VCR_IDX_CPOS_UP: cpos_up_nxt = i_io_wdata;
        `VCR_IDX_CPOS_LO: cpos_lo_nxt = i_io_wdata;
        `VCR_IDX_RT_BEGIN: begin
          if (i_timing_reg_readback) begin
            rt_begin_nxt = i_io_wdata;
          end
        end
        `VCR_IDX_RT_END: begin
          if (i_timing_reg_readback) begin
            rt_end_nxt = i_io_wdata;
          end
        end
        default: idx_nxt = idx_r;
      endcase
    end
    if (i_io_rd && idx_sel) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = idx_r;
    end
    if (i_io_rd && dat_sel) begin
      rvalid_nxt = 1'b1;
      case (idx_r)
        `VCR_IDX_CUR_TOP: rdata_nxt = cur_top_r;
        `VCR_IDX_CUR_BOT: rdata_nxt = cur_bot_r;
        `VCR_IDX_ORG_UP: rdata_nxt = org_up_r;
        `VCR_IDX_ORG_LO: rdata_nxt = org_lo_r;
        `VCR_IDX_CPOS_UP: rdata_nxt = cpos_up_r;
        `VCR_IDX_CPOS_LO: rdata_nxt = cpos_lo_r;
        `VCR_IDX_RT_BEGIN: begin
          rdata_nxt = i_timing_reg_readback ? rt_begin_r : 8'h00;
        end
        `VCR_IDX_RT_END: begin
          rdata_nxt = i_timing_reg_readback ? rt_end_r : 8'h00;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_r <= `VCR_IDX_RESET;
      cur_top_r <= `VCR_REG_RESET;
      cur_bot_r <= `VCR_REG_RESET;
      org_up_r <= `VCR_REG_RESET;
      org_lo_r <= `VCR_REG_RESET;
      cpos_up_r <= `VCR_REG_RESET;
      cpos_lo_r <= `VCR_REG_RESET;
      rt_begin_r <= `VCR_REG_RESET;
      rt_end_r <= `VCR_REG_RESET;
      o_io_rdata <= 8'h00;
      o_io_rdata_valid <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      cur_top_r <= cur_top_nxt;
      cur_bot_r <= cur_bot_nxt;
      org_up_r <= org_up_nxt;
      org_lo_r <= org_lo_nxt;
      cpos_up_r <= cpos_up_nxt;
      cpos_lo_r <= cpos_lo_nxt;
      rt_begin_r <= rt_begin_nxt;
      rt_end_r <= rt_end_nxt;
      o_io_rdata <= rdata_nxt;
      o_io_rdata_valid <= rvalid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // cursor unit
  // ----------------------------------------------------------------
  assign cur_if.top_line = cur_top_r[`VCR_LINE_MSB:0];
  assign cur_if.bot_line = cur_bot_r[`VCR_LINE_MSB:0];
  assign cur_if.on = cur_top_r[`VCR_CUR_ON_BIT];
  assign cur_if.delay = cur_bot_r[`VCR_DELAY_MSB:`VCR_DELAY_LSB];
  assign cur_if.pos = {cpos_up_r, cpos_lo_r};

  vcr_cursor #(
    .MAX_DELAY(3)
  ) u_cursor (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .cfg(cur_if.snk),
    .i_char_tick(i_char_tick),
    .i_row_scan(i_row_scan),
    .i_char_addr(i_char_addr),
    .o_cursor_pix(o_cursor_pix)
  );

  // ----------------------------------------------------------------
  // strike-through line
  // ----------------------------------------------------------------
  logic [4:0] strike_line_w;
  logic strike_nxt;

  always_comb begin
    case (cur_top_r[`VCR_STRIKE_MSB:`VCR_STRIKE_LSB])
      2'h0: strike_line_w = `VCR_STRIKE_L0;
      2'h1: strike_line_w = `VCR_STRIKE_L1;
      2'h2: strike_line_w = `VCR_STRIKE_L2;
      2'h3: strike_line_w = `VCR_STRIKE_L3;
      default: strike_line_w = `VCR_STRIKE_L0;
    endcase
    strike_nxt = i_extended_attr_enable &&
                 (i_row_scan == strike_line_w);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_strike_hit <= 1'b0;
    end else begin
      o_strike_hit <= strike_nxt;
    end
  end

  // ----------------------------------------------------------------
  // vertical retrace, origin load and retrace flag
  // ----------------------------------------------------------------
  vcr_rt_state_t rt_state_r, rt_state_nxt;
  logic [9:0] rt_begin_full;
  logic rt_hit_begin;
  logic rt_hit_end;
  logic flag_nxt;
  logic load_nxt;
  vcr_addr_t origin_nxt;

  assign rt_begin_full = {i_ovf_retrace_hi, rt_begin_r};

  always_comb begin
    rt_hit_begin = i_line_tick && (i_scan_line == rt_begin_full);
    rt_hit_end = i_line_tick &&
                 (i_scan_line[`VCR_RT_END_MSB:0] ==
                  rt_end_r[`VCR_RT_END_MSB:0]);
    rt_state_nxt = rt_state_r;
    origin_nxt = o_origin_addr;
    load_nxt = 1'b0;
    flag_nxt = o_retrace_flag;
    if (!rt_end_r[`VCR_IRQ_CLR_N_BIT]) begin
      flag_nxt = 1'b0;
    end
    case (rt_state_r)
      VCR_RT_IDLE: begin
        if (rt_hit_begin) begin
          rt_state_nxt = VCR_RT_ACTIVE;
          if (!rt_end_r[`VCR_IRQ_EN_N_BIT]) begin
            flag_nxt = 1'b1;
          end
        end
      end
      VCR_RT_ACTIVE: begin
        if (rt_hit_end) begin
          rt_state_nxt = VCR_RT_IDLE;
          origin_nxt = {org_up_r, org_lo_r};
          load_nxt = 1'b1;
        end
      end
      default: rt_state_nxt = VCR_RT_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rt_state_r <= VCR_RT_IDLE;
      o_vretrace <= 1'b0;
      o_retrace_flag <= 1'b0;
      o_origin_addr <= 16'h0000;
      o_origin_load <= 1'b0;
      o_register_write_lock <= 1'b0;
      o_refresh_five_cycles <= 1'b0;
    end else begin
      rt_state_r <= rt_state_nxt;
      o_vretrace <= (rt_state_nxt == VCR_RT_ACTIVE);
      o_retrace_flag <= flag_nxt;
      o_origin_addr <= origin_nxt;
      o_origin_load <= load_nxt;
      o_register_write_lock <= rt_end_nxt[`VCR_LOCK_BIT];
      o_refresh_five_cycles <= rt_end_nxt[`VCR_FIVE_CYC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_top_store: assert property (
    i_io_wr && dat_sel && (idx_r == `VCR_IDX_CUR_TOP)
    |=> cur_top_r == $past(i_io_wdata))
    else $error("cursor top register not written");

  a_rt_gate: assert property (
    i_io_wr && dat_sel && (idx_r == `VCR_IDX_RT_BEGIN) &&
    !i_timing_reg_readback |=> $stable(rt_begin_r))
    else $error("retrace start written without readback");

  a_lock_write: assert property (
    i_io_wr && dat_sel && (idx_r == `VCR_IDX_RT_END) &&
    i_timing_reg_readback && i_io_wdata[`VCR_LOCK_BIT]
    |=> o_register_write_lock)
    else $error("write lock not raised");

  a_rt_begin: assert property (
    (rt_state_r == VCR_RT_IDLE) && rt_hit_begin |=> o_vretrace)
    else $error("retrace did not begin");

  a_rt_finish: assert property (
    (rt_state_r == VCR_RT_ACTIVE) && rt_hit_end
    |=> !o_vretrace && o_origin_load)
    else $error("retrace did not end");

  a_origin_load: assert property (
    (rt_state_r == VCR_RT_ACTIVE) && rt_hit_end
    |=> o_origin_addr == {$past(org_up_r), $past(org_lo_r)})
    else $error("origin address not loaded");

  a_flag_latch: assert property (
    (rt_state_r == VCR_RT_IDLE) && rt_hit_begin &&
    !rt_end_r[`VCR_IRQ_EN_N_BIT] |=> o_retrace_flag)
    else $error("retrace flag not latched");

  a_strike_gate: assert property (
    !i_extended_attr_enable |=> !o_strike_hit)
    else $error("strike line without extended attributes");

endmodule

// File: vcr_top_bench.sv
// Purpose: self-checking bench of the cursor, origin and retrace group
// Assumes: inputs driven 1 ns after the rising clock edge
// Notes: register model in an array; expectations come from it
`timescale 1ns/100ps
`include "vcr_params.svh"
module vcr_top_bench;
  import vcr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic color = 1'b0;
  logic ext = 1'b0;
  logic rb = 1'b0;
  logic [1:0] ovf = 2'b00;
  logic ltick = 1'b0;
  logic [9:0] scan = 10'h000;
  logic ctick = 1'b0;
  logic [4:0] row = 5'h00;
  vcr_addr_t caddr = 16'h0000;
  logic [7:0] rdata;
  logic rvalid;
  logic pix;
  logic strike;
  logic vr;
  logic flag;
  vcr_addr_t org;
  logic oload;
  logic lock;
  logic five;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h7389_c7f4;
  logic [7:0] mdl [256];
  logic [4:0] lines [4] = '{5'h01, 5'h05, 5'h09, 5'h0d};

  vcr_top DUT (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_io_addr(addr),
    .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd),
    .i_color_mode(color), .i_extended_attr_enable(ext),
    .i_timing_reg_readback(rb), .i_ovf_retrace_hi(ovf),
    .i_line_tick(ltick), .i_scan_line(scan), .i_char_tick(ctick),
    .i_row_scan(row), .i_char_addr(caddr), .o_io_rdata(rdata),
    .o_io_rdata_valid(rvalid), .o_cursor_pix(pix),
    .o_strike_hit(strike), .o_vretrace(vr), .o_retrace_flag(flag),
    .o_origin_addr(org), .o_origin_load(oload),
    .o_register_write_lock(lock), .o_refresh_five_cycles(five)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] base();
    return color ? `VCR_IDX_PORT_COLOR : `VCR_IDX_PORT_MONO;
  endfunction

  function automatic bit reg_ok(input logic [7:0] i);
    return (i >= 8'h0a) && (i <= 8'h11) && (rb || i < 8'h10);
  endfunction

  function automatic logic cur_exp();
    logic [4:0] t;
    logic [4:0] b;
    t = mdl[8'h0a][4:0];
    b = mdl[8'h0b][4:0];
    return mdl[8'h0a][5] && t <= b && row >= t && row <= b &&
      caddr == {mdl[8'h0e], mdl[8'h0f]};
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input vcr_addr_t got, input vcr_addr_t exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t addr %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d);
    settle(1);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    settle(1);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    io(1'b1, base(), i);
    io(1'b1, base() + 16'h0001, v);
    if (reg_ok(i)) mdl[i] = v;
  endtask

  task automatic rreg(input logic [7:0] i);
    io(1'b1, base(), i);
    io(1'b0, base() + 16'h0001, 8'h00);
    chk_bit(rvalid, 1'b1);
    chk_byte(rdata, reg_ok(i) ? mdl[i] : 8'h00);
  endtask

  task automatic line(input logic [9:0] v);
    settle(1);
    scan = v;
    ltick = 1'b1;
    settle(1);
    ltick = 1'b0;
  endtask

  task automatic char_tick();
    settle(1);
    ctick = 1'b1;
    settle(1);
    ctick = 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("MISMATCH %0t run did not complete", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 256; k++) mdl[k] = 8'h00;
    settle(2);
    rst_n = 1'b1;
    chk_bit(vr, 1'b0);
    chk_addr(org, 16'h0000);
    // mono with readback closed, then colour with it open
    for (int m = 0; m < 2; m++) begin
      color = m[0];
      rb = m[0];
      for (int i = 10; i <= 18; i++) begin
        rreg(i[7:0]);
        seed = lfsr_next(seed);
        wreg(i[7:0], seed[7:0]);
        rreg(i[7:0]);
      end
    end
    io(1'b0, `VCR_DAT_PORT_MONO, 8'h00);
    chk_bit(rvalid, 1'b0);
    io(1'b0, `VCR_IDX_PORT_COLOR, 8'h00);
    chk_byte(rdata, 8'h12);
    chk_bit(lock, mdl[8'h11][7]);
    chk_bit(five, mdl[8'h11][6]);
    // random cursor shapes, skew 0
    wreg(8'h0e, 8'h12);
    wreg(8'h0f, 8'h34);
    for (int n = 0; n < 64; n++) begin
      seed = lfsr_next(seed);
      wreg(8'h0a, {2'b00, seed[0] | seed[13], 1'b0, seed[4:1]});
      wreg(8'h0b, {4'h0, seed[8:5]});
      row = {1'b0, seed[12:9]};
      caddr = (seed[16] | seed[17]) ? 16'h1234 : 16'h1235;
      settle(2);
      chk_bit(pix, cur_exp());
    end
    // skew of one to three character times, delay line flushed first
    wreg(8'h0a, 8'h22);
    row = 5'h03;
    for (int d = 1; d < 4; d++) begin
      wreg(8'h0b, {1'b0, d[1:0], 5'h05});
      caddr = 16'h1235;
      repeat (3) char_tick();
      caddr = 16'h1234;
      for (int t = 0; t < 4; t++) begin
        char_tick();
        settle(2);
        chk_bit(pix, t >= d - 1);
      end
    end
    // strike-through line per select code
    ext = 1'b1;
    for (int s = 0; s < 4; s++) begin
      wreg(8'h0a, {s[1:0], 6'h00});
      for (int l = 0; l < 4; l++) begin
        row = lines[l];
        settle(2);
        chk_bit(strike, l == s);
      end
    end
    ext = 1'b0;
    settle(2);
    chk_bit(strike, 1'b0);
    // retrace start 123, end nibble 9, flag enabled
    ovf = 2'b01;
    wreg(8'h10, 8'h23);
    wreg(8'h11, 8'hd9);
    wreg(8'h0c, 8'hab);
    wreg(8'h0d, 8'hcd);
    settle(2);
    chk_bit(lock, 1'b1);
    line(10'h023);
    chk_bit(vr, 1'b0);
    line(10'h123);
    chk_bit(vr, 1'b1);
    line(10'h124);
    chk_bit(vr, 1'b1);
    chk_bit(flag, 1'b1);
    line(10'h129);
    chk_bit(vr, 1'b0);
    chk_bit(oload, 1'b1);
    chk_addr(org, 16'habcd);
    settle(1);
    chk_bit(oload, 1'b0);
    chk_bit(flag, 1'b1);
    wreg(8'h11, 8'h49);
    settle(2);
    chk_bit(flag, 1'b0);
    chk_bit(lock, 1'b0);
    // flag stays low with the interrupt disabled
    wreg(8'h11, 8'h39);
    line(10'h123);
    settle(2);
    chk_bit(vr, 1'b1);
    chk_bit(flag, 1'b0);
    line(10'h129);
    chk_bit(vr, 1'b0);
    // set and clear of the flag in one cycle: set wins
    wreg(8'h11, 8'h09);
    line(10'h123);
    chk_bit(flag, 1'b1);
    settle(1);
    chk_bit(flag, 1'b0);
    line(10'h129);
    chk_bit(vr, 1'b0);
    tally_and_finish();
  end
endmodule
